// ---- dv/mem_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model (
    input wire logic clock_i,
    output logic cmd_valid_o,
    output logic ras_n_o,
    output logic cas_n_o,
    output logic we_n_o,
    output logic dev_select_o,
    output logic [21:0] addr_o,
    output logic read_cmd_o,
    output logic sync_pulse_o
);
    localparam logic [21:0] RSV_MASK = 22'h220001;
    initial begin
        cmd_valid_o = 1'b0;
        ras_n_o = 1'b1;
        cas_n_o = 1'b1;
        we_n_o = 1'b1;
        dev_select_o = 1'b0;
        addr_o = 22'h000000;
        read_cmd_o = 1'b0;
        sync_pulse_o = 1'b0;
    end
    // Issues only set and read commands, with all banks taken as idle.
    task automatic issue(input logic [21:0] a, input logic rd, input logic sel);
        logic [21:0] a_ok;
        a_ok = rd ? a : (a & ~RSV_MASK);
        @(negedge clock_i);
        cmd_valid_o = 1'b1;
        ras_n_o = rd;
        cas_n_o = 1'b0;
        we_n_o = rd;
        read_cmd_o = rd;
        dev_select_o = sel;
        addr_o = a_ok;
        @(negedge clock_i);
        cmd_valid_o = 1'b0;
        ras_n_o = 1'b1;
        cas_n_o = 1'b1;
        we_n_o = 1'b1;
        read_cmd_o = 1'b0;
        dev_select_o = ~sel;
        addr_o = ~a_ok;
    endtask
    // A one-cycle sync pulse follows the gear-down set command.
    task automatic sync_pulse();
        @(negedge clock_i);
        sync_pulse_o = 1'b1;
        @(negedge clock_i);
        sync_pulse_o = 1'b0;
    endtask
endmodule // mem_ctrl_model
`default_nettype wire

// ---- dv/test_sdram_mode_reg_mpr_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_sdram_mode_reg_mpr_control;
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [1:0] temp_sensor_i = 2'h0;
    logic cmd_valid, ras_n, cas_n, we_n, dev_sel, rd_cmd, sync_p;
    logic [21:0] addr;
    logic store_mode_o, store_data_valid_o, quarter_rate_o, per_device_o, cmd_delay_reserved_o;
    logic rd_train_o, sr_abort_o, temporary_row_repair_o, permanent_row_repair_o;
    logic vref_monitor_o, tcr_enable_o, tcr_extended_o, max_power_save_o;
    logic [2:0] read_format_o;
    logic [7:0] store_data_o;
    logic [3:0] write_cmd_delay_o, cmd_delay_o;
    logic [1:0] wr_preamble_o, rd_preamble_o;
    logic [21:0] mode_word_four_o;
    int err_count = 0;
    int compares = 0;
    always #5 clock_i = ~clock_i;
    mem_ctrl_model mem_ctrl_model_inst (.clock_i(clock_i), .cmd_valid_o(cmd_valid),
        .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .dev_select_o(dev_sel),
        .addr_o(addr), .read_cmd_o(rd_cmd), .sync_pulse_o(sync_p));
    mode_word_ctrl #(.TEMP_AGE_CYCLES(8)) mode_word_ctrl_inst (.clock_i(clock_i),
        .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid), .ras_n_i(ras_n), .cas_n_i(cas_n),
        .we_n_i(we_n), .dev_select_i(dev_sel), .addr_i(addr), .read_cmd_i(rd_cmd),
        .sync_pulse_i(sync_p), .temp_sensor_i(temp_sensor_i), .store_mode_o(store_mode_o),
        .read_format_o(read_format_o), .store_data_o(store_data_o),
        .store_data_valid_o(store_data_valid_o), .quarter_rate_o(quarter_rate_o),
        .per_device_o(per_device_o), .write_cmd_delay_o(write_cmd_delay_o),
        .cmd_delay_o(cmd_delay_o), .cmd_delay_reserved_o(cmd_delay_reserved_o),
        .wr_preamble_o(wr_preamble_o), .rd_preamble_o(rd_preamble_o), .rd_train_o(rd_train_o),
        .sr_abort_o(sr_abort_o), .temporary_row_repair_o(temporary_row_repair_o),
        .permanent_row_repair_o(permanent_row_repair_o), .vref_monitor_o(vref_monitor_o),
        .tcr_enable_o(tcr_enable_o), .tcr_extended_o(tcr_extended_o),
        .max_power_save_o(max_power_save_o), .mode_word_four_o(mode_word_four_o));
    task automatic check(input string name, input logic [21:0] exp, input logic [21:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [21:0] a, input logic sel);
        mem_ctrl_model_inst.issue(a, 1'b0, sel);
        repeat (2) @(negedge clock_i);
    endtask
    task automatic do_read(input logic [21:0] a, output logic ok, output logic [7:0] d);
        ok = 1'b0;
        d = 8'h00;
        mem_ctrl_model_inst.issue(a, 1'b1, 1'b1);
        for (int i = 0; i < 5; i++) begin
            @(negedge clock_i);
            if (store_data_valid_o === 1'b1 && !ok) begin
                ok = 1'b1;
                d = store_data_o;
            end
        end
    endtask
    task automatic test_word_four();
        logic [21:0] v;
        logic [7:0] f;
        logic [3:0] dly [8];
        dly = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h0, 4'h0};
        check("wcd_reset", 22'h4, write_cmd_delay_o);
        check("format_reset", 22'h1, read_format_o);
        check("word4_reset", 22'h0, mode_word_four_o);
        for (int c = 0; c < 8; c++) begin
            wr(22'h100000 | (22'(c) << 6), 1'b1);
            check("cmd_delay", 22'(dly[c]), 22'(cmd_delay_o));
            check("cmd_delay_rsv", 22'(c >= 6), 22'(cmd_delay_reserved_o));
        end
        for (int k = 0; k < 2; k++) begin
            v = (k == 1) ? 22'h001414 : 22'h002A2A;
            wr(22'h100000 | v, 1'b1);
            f = {permanent_row_repair_o, rd_train_o, sr_abort_o, temporary_row_repair_o,
                 vref_monitor_o, tcr_enable_o, tcr_extended_o, max_power_save_o};
            check("flags", {v[13], v[10], v[9], v[5:1]}, f);
            check("wr_pre", 22'h1 + v[12], wr_preamble_o);
            check("rd_pre", 22'h1 + v[11], rd_preamble_o);
            check("word4", v[15:0], mode_word_four_o[15:0]);
        end
        $display("test_word_four done");
    endtask
    task automatic test_word_three();
        for (int i = 0; i < 4; i++) begin
            wr(22'h0C0000 | (22'(i) << 11) | (22'(i) << 9), 1'b1);
            check("format", (i < 3) ? (22'h1 << i) : 22'h0, read_format_o);
            check("wcd", (i < 3) ? 22'(4 + i) : 22'h0, write_cmd_delay_o);
        end
        $display("test_word_three done");
    endtask
    task automatic test_readout();
        logic ok;
        logic [7:0] d;
        logic [7:0] up [3];
        logic [7:0] lo [3];
        up = '{8'hFF, 8'h03, 8'h06};
        lo = '{8'h00, 8'hA6, 8'h4D};
        wr(22'h1018A6, 1'b1);
        do_read(22'h000024, ok, d);
        check("read_refused", 22'h0, ok);
        for (int f = 0; f < 3; f++) begin
            wr(22'h0C0004 | (22'(f) << 11), 1'b1);
            check("store_mode", 22'h1, store_mode_o);
            do_read(22'h000024, ok, d);
            check("upper", up[f], d);
            do_read(22'h000020, ok, d);
            check("lower", lo[f], d);
        end
        wr(22'h141FFE, 1'b1);
        check("word4_kept", 22'h18A6, mode_word_four_o[15:0]);
        check("store_kept", 22'h1, store_mode_o);
        $display("test_readout done");
    endtask
    task automatic test_temp();
        logic ok;
        logic [7:0] d;
        temp_sensor_i = 2'h2;
        wr(22'h0C0826, 1'b1);
        repeat (30) @(negedge clock_i);
        do_read(22'h000000, ok, d);
        check("temp_page", 22'hD0, d);
        temp_sensor_i = 2'h1;
        repeat (30) @(negedge clock_i);
        do_read(22'h000000, ok, d);
        check("temp_page", 22'hC8, d);
        wr(22'h0C0000, 1'b1);
        $display("test_temp done");
    endtask
    task automatic test_gear();
        wr(22'h0C0008, 1'b1);
        repeat (6) @(negedge clock_i);
        check("half_rate", 22'h0, quarter_rate_o);
        mem_ctrl_model_inst.sync_pulse();
        repeat (6) @(negedge clock_i);
        check("quarter_rate", 22'h1, quarter_rate_o);
        wr(22'h101880, 1'b1);
        check("cmd_delay", 22'h4, cmd_delay_o);
        $display("test_gear done");
    endtask
    task automatic test_per_device();
        wr(22'h0C0010, 1'b1);
        check("per_device", 22'h1, per_device_o);
        wr(22'h100002, 1'b0);
        check("masked", 22'h0, max_power_save_o);
        wr(22'h100002, 1'b1);
        check("selected", 22'h1, max_power_save_o);
        wr(22'h0C0004, 1'b1);
        check("store_mode", 22'h1, store_mode_o);
        sys_rst_i = 1'b1;
        repeat (2) @(negedge clock_i);
        sys_rst_i = 1'b0;
        @(negedge clock_i);
        check("store_reset", 22'h0, store_mode_o);
        check("word4_reset", 22'h0, mode_word_four_o);
        check("quarter_reset", 22'h0, quarter_rate_o);
        $display("test_per_device done");
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(negedge clock_i);
        sys_rst_i = 1'b0;
        test_word_four();
        test_word_three();
        test_readout();
        test_temp();
        test_gear();
        test_per_device();
        report_and_stop();
    end
endmodule // test_sdram_mode_reg_mpr_control
`default_nettype wire

// ---- rtl/mode_word_ctrl.sv ----
// What this block does
// - A set command writing one to word three bit 2 enters readout store mode.
// - Readout store data is formatted by word three bits 12 and 11.
// - In readout store mode every unmasked read is redirected to an addressed mode word, except page 2 word 0, which returns the status byte.
// - Each mode word is read as an upper or lower half.
// - Reset is accepted in readout store mode and clears all state.
// - Temperature status goes to page 2 word 0 bits 4:3, refreshed within 32 ms.
// - Per-device addressability lets a device ignore masked commands.
// - Device starts half rate; quarter rate waits for a sync pulse.
// - Word four is written when strobes are low and select is 100.
// - Bits 12 and 11 set write and read preamble length.
// - Bits 8:6 set chip-select-to-command delay 0,3,4,5,6,8; 110/111 reserved.
// - Bit 13 enables permanent repair; availability in page 2 word 0 bit 7.
// - Bit 5 enables temporary row repair.
// - Bit 3 enables temperature refresh; bit 2 picks its range.
// - Bit 1 enables maximum power saving.
// - Bit 9 enables self refresh abort; bit 10 read preamble training.
// - Read format 00 serial, 01 parallel, 10 staggered; gear bit 3.
// - Write command delay field bits 10:9 select 4, 5, 6 clocks.
`timescale 1ns/1ps
`default_nettype none
module mode_word_ctrl #(
    parameter int TEMP_AGE_CYCLES = mode_word_pkg::TEMP_AGE_CYCLES,
    parameter logic PERM_REPAIR_AVAIL = 1'b1,
    parameter logic TMP_REPAIR_AVAIL = 1'b1
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic cmd_valid_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic dev_select_i,
    input wire logic [21:0] addr_i,
    input wire logic read_cmd_i,
    input wire logic sync_pulse_i,
    input wire logic [1:0] temp_sensor_i,
    output logic store_mode_o,
    output logic [2:0] read_format_o,
    output logic [7:0] store_data_o,
    output logic store_data_valid_o,
    output logic quarter_rate_o,
    output logic per_device_o,
    output logic [3:0] write_cmd_delay_o,
    output logic [3:0] cmd_delay_o,
    output logic cmd_delay_reserved_o,
    output logic [1:0] wr_preamble_o,
    output logic [1:0] rd_preamble_o,
    output logic rd_train_o,
    output logic sr_abort_o,
    output logic temporary_row_repair_o,
    output logic permanent_row_repair_o,
    output logic vref_monitor_o,
    output logic tcr_enable_o,
    output logic tcr_extended_o,
    output logic max_power_save_o,
    output logic [21:0] mode_word_four_o
);
    logic [21:0] mode_word_three;
    logic [21:0] mode_word_four;
    logic [1:0] temp_meta;
    logic [1:0] temp_sync;
    logic [1:0] temp_status;
    logic [31:0] temp_age;
    logic gear_pending;
    logic read_pending;
    logic read_upper;
    logic [2:0] read_sel;
    logic [1:0] read_page;
    logic [1:0] read_slot;
    logic [21:0] stored_word;
    logic sync_meta;
    logic sync_seen;

    wire set_cmd = cmd_valid_i && !ras_n_i && !cas_n_i && !we_n_i;
    wire dev_ok = !mode_word_three[mode_word_pkg::F3_PER_DEV] || dev_select_i;
    wire set_accept = set_cmd && dev_ok;
    wire [2:0] set_sel = addr_i[mode_word_pkg::SEL_MSB:mode_word_pkg::SEL_LSB];
    wire write_three = set_accept && set_sel == mode_word_pkg::SEL_WORD_THREE;
    wire write_four = set_accept && set_sel == mode_word_pkg::SEL_WORD_FOUR;
    wire store_on = mode_word_three[mode_word_pkg::F3_STORE_EN];
    wire read_take = read_cmd_i && cmd_valid_i && store_on && dev_ok;
    wire [1:0] fmt_code = mode_word_three[mode_word_pkg::F3_FMT_LSB +: 2];
    wire [1:0] wcd_code = mode_word_three[mode_word_pkg::F3_WCD_LSB +: 2];
    wire [2:0] cd_code = mode_word_four[mode_word_pkg::F4_CMD_DLY_LSB +: 3];
    wire [7:0] page_two_word0 = {PERM_REPAIR_AVAIL, TMP_REPAIR_AVAIL, 1'b0,
        temp_status, 3'h0};
    wire [2:0] rd_sel = read_take ? addr_i[5:3] : read_sel;

    // Full mode word copy, one slot per select code, written on set commands.
    mode_word_store #(
        .WIDTH(22),
        .DEPTH(mode_word_pkg::WORD_SLOTS)
    ) u_store (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .wr_en_i(set_accept),
        .wr_sel_i(set_sel),
        .wr_data_i(addr_i),
        .rd_sel_i(rd_sel),
        .rd_data_o(stored_word)
    );

    function automatic logic [3:0] cmd_delay_clocks(input logic [2:0] code);
        case (code)
            3'h0: cmd_delay_clocks = 4'h0;
            3'h1: cmd_delay_clocks = 4'h3;
            3'h2: cmd_delay_clocks = 4'h4;
            3'h3: cmd_delay_clocks = 4'h5;
            3'h4: cmd_delay_clocks = 4'h6;
            3'h5: cmd_delay_clocks = 4'h8;
            default: cmd_delay_clocks = 4'h0;
        endcase
    endfunction

    function automatic logic [3:0] wcd_clocks(input logic [1:0] code);
        case (code)
            2'h0: wcd_clocks = 4'h4;
            2'h1: wcd_clocks = 4'h5;
            2'h2: wcd_clocks = 4'h6;
            default: wcd_clocks = 4'h0;
        endcase
    endfunction

    // Reset clears every mode word, so initialization must be repeated.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            mode_word_three <= mode_word_pkg::WORD_RESET;
            mode_word_four <= mode_word_pkg::WORD_RESET;
        end else begin
            if (write_three) begin
                mode_word_three <= addr_i;
            end
            if (write_four) begin
                mode_word_four <= addr_i;
            end
        end
    end

    // Quarter rate takes effect only once a sync pulse follows the set command.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sync_meta <= 1'b0;
            sync_seen <= 1'b0;
            gear_pending <= 1'b0;
            quarter_rate_o <= 1'b0;
        end else begin
            sync_meta <= sync_pulse_i;
            sync_seen <= sync_meta;
            if (write_three && addr_i[mode_word_pkg::F3_GEAR]) begin
                gear_pending <= 1'b1;
            end else if (gear_pending && sync_seen) begin
                gear_pending <= 1'b0;
            end
            if (write_three && !addr_i[mode_word_pkg::F3_GEAR]) begin
                quarter_rate_o <= 1'b0;
            end else if (gear_pending && sync_seen) begin
                quarter_rate_o <= 1'b1;
            end
        end
    end

    // Temperature status sampled once every TEMP_AGE_CYCLES clocks, the full age limit.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            temp_meta <= 2'h0;
            temp_sync <= 2'h0;
            temp_status <= 2'h0;
            temp_age <= 32'h00000000;
        end else begin
            temp_meta <= temp_sensor_i;
            temp_sync <= temp_meta;
            if (!mode_word_three[mode_word_pkg::F3_TEMP_EN]) begin
                temp_age <= 32'h00000000;
            end else if (temp_age >= 32'(TEMP_AGE_CYCLES - 1)) begin
                temp_age <= 32'h00000000;
                temp_status <= temp_sync;
            end else begin
                temp_age <= temp_age + 32'h00000001;
            end
        end
    end

    // Read in store mode: address picks word, half and slot; word three picks page.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            read_pending <= 1'b0;
            read_upper <= 1'b0;
            read_sel <= 3'h0;
            read_page <= 2'h0;
            read_slot <= 2'h0;
        end else begin
            read_pending <= read_take;
            if (read_take) begin
                read_sel <= addr_i[5:3];
                read_upper <= addr_i[2];
                read_slot <= addr_i[1:0];
                read_page <= mode_word_three[mode_word_pkg::F3_PAGE_LSB +: 2];
            end
        end
    end

    wire from_page_two = read_page == 2'(mode_word_pkg::PAGE_TWO) && read_slot == 2'h0;
    wire [10:0] half_word = read_upper ? stored_word[21:11] : stored_word[10:0];
    wire [7:0] raw_byte = from_page_two ? page_two_word0 : half_word[7:0];
    wire [7:0] fmt_byte = fmt_code == 2'h0 ? {8{raw_byte[0]}} :
        fmt_code == 2'h2 ? {raw_byte[6:0], raw_byte[7]} : raw_byte;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            store_data_o <= 8'h00;
            store_data_valid_o <= 1'b0;
        end else begin
            store_data_valid_o <= read_pending;
            if (read_pending) begin
                store_data_o <= fmt_byte;
            end
        end
    end

    assign store_mode_o = store_on;
    assign read_format_o = fmt_code == 2'h0 ? mode_word_pkg::FMT_SERIAL :
        fmt_code == 2'h1 ? mode_word_pkg::FMT_PARALLEL :
        fmt_code == 2'h2 ? mode_word_pkg::FMT_STAGGERED : 3'h0;
    assign per_device_o = mode_word_three[mode_word_pkg::F3_PER_DEV];
    assign write_cmd_delay_o = wcd_clocks(wcd_code);
    assign cmd_delay_o = cmd_delay_clocks(cd_code);
    assign cmd_delay_reserved_o = cd_code[2] && cd_code[1];
    assign wr_preamble_o = mode_word_four[mode_word_pkg::F4_WR_PRE] ? 2'h2 : 2'h1;
    assign rd_preamble_o = mode_word_four[mode_word_pkg::F4_RD_PRE] ? 2'h2 : 2'h1;
    assign rd_train_o = mode_word_four[mode_word_pkg::F4_RD_TRAIN];
    assign sr_abort_o = mode_word_four[mode_word_pkg::F4_SR_ABORT];
    assign temporary_row_repair_o = mode_word_four[mode_word_pkg::F4_TMP_REPAIR];
    assign permanent_row_repair_o = mode_word_four[mode_word_pkg::F4_PERM_REPAIR]
        && PERM_REPAIR_AVAIL;
    assign vref_monitor_o = mode_word_four[mode_word_pkg::F4_VREF_MON];
    assign tcr_enable_o = mode_word_four[mode_word_pkg::F4_TCR_EN];
    assign tcr_extended_o = mode_word_four[mode_word_pkg::F4_TCR_RANGE];
    assign max_power_save_o = mode_word_four[mode_word_pkg::F4_MAX_PWR];
    assign mode_word_four_o = mode_word_four;

    a_store_enter: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        write_three && addr_i[2] |=> store_mode_o)
        else $error("store mode not entered");
    a_read_answer: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        read_take |-> ##2 store_data_valid_o)
        else $error("redirected read gave no data");
    a_no_read_idle: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !store_on |=> ##1 !store_data_valid_o)
        else $error("read answered outside store mode");
    a_serial_fmt: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        store_data_valid_o && $past(fmt_code) == 2'h0 |-> store_data_o == {8{store_data_o[0]}})
        else $error("serial byte not uniform");
    a_upper_half: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        store_data_valid_o && $past(fmt_code) == 2'h1 && $past(read_upper)
        && !$past(from_page_two) |-> store_data_o == $past(stored_word[18:11]))
        else $error("upper half byte wrong");
    a_page_two: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        store_data_valid_o && $past(fmt_code) == 2'h1 && $past(from_page_two)
        |-> {store_data_o[7], store_data_o[4:3]} == {PERM_REPAIR_AVAIL, $past(temp_status)})
        else $error("page two word zero wrong");
    a_temp_fresh: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        temp_age < 32'(TEMP_AGE_CYCLES))
        else $error("temperature status too old");
    a_word4_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !write_four |=> $stable(mode_word_four))
        else $error("word four changed without its write");
    a_word3_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !write_three |=> $stable(mode_word_three))
        else $error("word three changed without its write");
    a_word4_load: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        write_four |=> mode_word_four_o == $past(addr_i))
        else $error("word four not loaded");
    a_preamble_set: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        write_four |=> wr_preamble_o == ($past(addr_i[mode_word_pkg::F4_WR_PRE]) ? 2'h2 : 2'h1)
        && rd_preamble_o == ($past(addr_i[mode_word_pkg::F4_RD_PRE]) ? 2'h2 : 2'h1))
        else $error("preamble length wrong");
    a_repair_set: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        write_four |=> temporary_row_repair_o == $past(addr_i[mode_word_pkg::F4_TMP_REPAIR])
        && permanent_row_repair_o == ($past(addr_i[mode_word_pkg::F4_PERM_REPAIR])
        && PERM_REPAIR_AVAIL))
        else $error("repair enable wrong");
    a_refresh_set: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        write_four |=> tcr_enable_o == $past(addr_i[mode_word_pkg::F4_TCR_EN])
        && tcr_extended_o == $past(addr_i[mode_word_pkg::F4_TCR_RANGE])
        && max_power_save_o == $past(addr_i[mode_word_pkg::F4_MAX_PWR]))
        else $error("refresh or power flag wrong");
    a_abort_train: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        write_four |=> sr_abort_o == $past(addr_i[mode_word_pkg::F4_SR_ABORT])
        && rd_train_o == $past(addr_i[mode_word_pkg::F4_RD_TRAIN]))
        else $error("abort or training flag wrong");
    a_cmd_delay_map: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        cd_code == 3'h5 |-> cmd_delay_o == 4'h8)
        else $error("delay code 101 not 8 clocks");
    a_cmd_delay_rsv: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        cd_code[2:1] == 2'h3 |-> cmd_delay_reserved_o && cmd_delay_o == 4'h0)
        else $error("reserved delay code not flagged");
    a_wcd_map: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        wcd_code == 2'h2 |-> write_cmd_delay_o == 4'h6)
        else $error("write delay code 10 not 6 clocks");
    a_wcd_rsv: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        wcd_code == 2'h3 |-> write_cmd_delay_o == 4'h0)
        else $error("reserved write delay not zero");
    a_format_map: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        fmt_code == 2'h1 |-> read_format_o == mode_word_pkg::FMT_PARALLEL)
        else $error("parallel format code wrong");
    a_gear_sync: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        $rose(quarter_rate_o) |-> $past(gear_pending) && $past(sync_seen))
        else $error("quarter rate without sync");
    a_quarter_drop: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        write_three && !addr_i[mode_word_pkg::F3_GEAR] |=> !quarter_rate_o)
        else $error("half rate not restored");
    a_half_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !quarter_rate_o && !gear_pending |=> !quarter_rate_o)
        else $error("quarter rate without request");
    a_mask_dev: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        set_cmd && per_device_o && !dev_select_i |=> $stable(mode_word_four))
        else $error("masked device took command");
    a_word3_mask: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        set_cmd && per_device_o && !dev_select_i |=> $stable(mode_word_three))
        else $error("masked device changed word three");
    a_reset_clear: assert property (@(posedge clock_i)
        sys_rst_i |=> !store_mode_o && !quarter_rate_o)
        else $error("reset did not clear mode");
    c_store_read: cover property (@(posedge clock_i) disable iff (sys_rst_i)
        read_take ##2 store_data_valid_o);
    c_word_four: cover property (@(posedge clock_i) disable iff (sys_rst_i) write_four);
    c_quarter: cover property (@(posedge clock_i) disable iff (sys_rst_i) $rose(quarter_rate_o));
    c_masked_set: cover property (@(posedge clock_i) disable iff (sys_rst_i)
        set_cmd && per_device_o && !dev_select_i);
    c_page_two: cover property (@(posedge clock_i) disable iff (sys_rst_i)
        read_take && mode_word_three[1:0] == 2'h2);
endmodule // mode_word_ctrl
`default_nettype wire

// ---- rtl/mode_word_pkg.sv ----
package mode_word_pkg;
    localparam int ADDR_BITS = 22;
    localparam logic [2:0] SEL_WORD_THREE = 3'h3;
    localparam logic [2:0] SEL_WORD_FOUR = 3'h4;
    localparam int SEL_MSB = 20;
    localparam int SEL_LSB = 18;
    localparam int F3_STORE_EN = 2;
    localparam int F3_GEAR = 3;
    localparam int F3_PER_DEV = 4;
    localparam int F3_TEMP_EN = 5;
    localparam int F3_FGR_LSB = 6;
    localparam int F3_WCD_LSB = 9;
    localparam int F3_FMT_LSB = 11;
    localparam int F3_PAGE_LSB = 0;
    localparam int F4_MAX_PWR = 1;
    localparam int F4_TCR_RANGE = 2;
    localparam int F4_TCR_EN = 3;
    localparam int F4_VREF_MON = 4;
    localparam int F4_TMP_REPAIR = 5;
    localparam int F4_CMD_DLY_LSB = 6;
    localparam int F4_SR_ABORT = 9;
    localparam int F4_RD_TRAIN = 10;
    localparam int F4_RD_PRE = 11;
    localparam int F4_WR_PRE = 12;
    localparam int F4_PERM_REPAIR = 13;
    localparam logic [21:0] WORD_RESET = 22'h000000;
    localparam int WORD_SLOTS = 8;
    localparam int TEMP_AGE_MS = 32;
    localparam int CLOCK_MHZ = 100;
    localparam int TEMP_AGE_CYCLES = TEMP_AGE_MS * 1000 * CLOCK_MHZ;
    localparam int PAGE_TWO = 2;
    localparam int PERM_AVAIL_BIT = 7;
    localparam int TMP_AVAIL_BIT = 6;
    localparam int TEMP_LSB = 3;
    typedef enum logic [2:0] {
        FMT_SERIAL = 3'h1,
        FMT_PARALLEL = 3'h2,
        FMT_STAGGERED = 3'h4
    } read_format_t;
endpackage

// ---- rtl/mode_word_store.sv ----
`timescale 1ns/1ps
`default_nettype none
module mode_word_store #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 8
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic wr_en_i,
    input wire logic [$clog2(DEPTH)-1:0] wr_sel_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic [$clog2(DEPTH)-1:0] rd_sel_i,
    output logic [WIDTH-1:0] rd_data_o
);
    localparam int SEL_W = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    genvar i;
    // Only the selected slot takes a write; the others hold.
    generate
        for (i = 0; i < DEPTH; i++) begin : g_slot
            always_ff @(posedge clock_i) begin
                if (sys_rst_i) begin
                    mem[i] <= '0;
                end else if (wr_en_i && wr_sel_i == SEL_W'(i)) begin
                    mem[i] <= wr_data_i;
                end
            end
        end
    endgenerate
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= mem[rd_sel_i];
        end
    end
endmodule // mode_word_store
`default_nettype wire
